// *** urr_pkg.sv ***
`default_nettype none

// ==========================================================================
// Shared constants and types for the UART register reset block.
// ==========================================================================
package urr_pkg;

	// ======================================================================
	// Register byte addresses on the APB bus.
	// ======================================================================
	localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'h00; // Interrupt enable.
	localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h04; // Interrupt status, read only.
	localparam logic [7:0] ADDR_FIFO_CONTROL     = 8'h08; // FIFO control.
	localparam logic [7:0] ADDR_LINE_CONTROL     = 8'h0c; // Line control.
	localparam logic [7:0] ADDR_MODEM_CONTROL    = 8'h10; // Modem control.
	localparam logic [7:0] ADDR_LINE_STATUS      = 8'h14; // Line status, read only.
	localparam logic [7:0] ADDR_MODEM_STATUS     = 8'h18; // Modem status, read only.
	localparam logic [7:0] ADDR_EXTRA_FEATURE    = 8'h1c; // Extra feature control.
	localparam logic [7:0] ADDR_SCRATCH          = 8'h20; // Scratch.
	localparam logic [7:0] ADDR_DIVISOR_LOW      = 8'h24; // Divisor low.
	localparam logic [7:0] ADDR_DIVISOR_HIGH     = 8'h28; // Divisor high.
	localparam logic [7:0] ADDR_TX_LEVEL         = 8'h2c; // Transmit FIFO level, read only.
	localparam logic [7:0] ADDR_RX_LEVEL         = 8'h30; // Receive FIFO level, read only.
	localparam logic [7:0] ADDR_ENHANCED_FEATURE = 8'h34; // Enhanced feature.
	localparam logic [7:0] ADDR_RESUME_ONE       = 8'h38; // Flow resume character one.
	localparam logic [7:0] ADDR_RESUME_TWO       = 8'h3c; // Flow resume character two.
	localparam logic [7:0] ADDR_PAUSE_ONE        = 8'h40; // Flow pause character one.
	localparam logic [7:0] ADDR_PAUSE_TWO        = 8'h44; // Flow pause character two.
	localparam logic [7:0] ADDR_TX_TRIGGER       = 8'h48; // Transmit trigger level.
	localparam logic [7:0] ADDR_RX_TRIGGER       = 8'h4c; // Receive trigger level.
	localparam logic [7:0] ADDR_FLOW_HIGH        = 8'h50; // Flow threshold high.
	localparam logic [7:0] ADDR_FLOW_LOW         = 8'h54; // Flow threshold low.
	localparam logic [7:0] ADDR_PRESCALER        = 8'h58; // Clock prescaler.
	localparam logic [7:0] ADDR_SAMPLING         = 8'h5c; // Sampling rate.
	localparam logic [7:0] ADDR_ADV_CONTROL      = 8'h60; // Advanced control, holds the soft reset bit.
	localparam logic [7:0] ADDR_RESET_STATUS     = 8'h64; // Reset in progress flag, read only.

	// ======================================================================
	// Field positions and reset values.
	// ======================================================================
	localparam int         SOFT_RESET_BIT      = 1;     // Soft reset bit in the advanced control register.
	localparam logic [7:0] RESET_ZERO          = 8'h00; // Cleared register.
	localparam logic [7:0] RESET_INT_STATUS    = 8'h01; // No interrupt pending.
	localparam logic [7:0] RESET_LINE_STATUS   = 8'h60; // Transmitter empty.
	localparam logic [7:0] RESET_SCRATCH       = 8'h01; // Scratch reset value.
	localparam logic [7:0] DIVISOR_POWERUP     = 8'h01; // Arbitrary known value for unspecified registers.
	localparam logic [7:0] FLOW_CHAR_POWERUP   = 8'h00; // Arbitrary known value for flow characters.
	localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000; // Read data of an unmapped address.

	// ======================================================================
	// Timing.
	// ======================================================================
	localparam int         RESET_CLOCKS        = 4;     // Clocks a reset takes to complete.
	localparam logic [2:0] RESET_COUNT_LAST    = 3'(RESET_CLOCKS - 1); // Last count of a reset.

	// Sequencer states.
	typedef enum logic [0:0] {
		URR_RUN   = 1'b0,
		URR_RESET = 1'b1
	} urr_state_t;

	// APB request from the master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} urr_apb_req_t;

	// APB answer to the master.
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} urr_apb_rsp_t;

	// Modem input pin levels; the register bank synchronises them.
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} urr_modem_in_t;

endpackage

`default_nettype wire

// *** urr_reset_seq.sv ***
`default_nettype none

// ==========================================================================
// Reset sequencer: merges pin and soft reset into one four clock reset.
// ==========================================================================
module urr_reset_seq
	import urr_pkg::*;
(
	input  wire logic clk_sys,          // System clock.
	input  wire logic reset,            // Pin reset, synchronous, active high.
	input  wire logic soft_request,     // One cycle soft reset request.
	output logic      regs_reset,       // Level: registers held in reset state.
	output logic      reset_done        // One cycle pulse when a reset completes.
);

	// All state of the sequencer.
	typedef struct packed {
		urr_state_t state;
		logic [2:0] count;
		logic       busy;
		logic       done;
	} urr_seq_t;

	urr_seq_t seq_q; // Registered state.
	urr_seq_t seq_d; // Next state.

	// ======================================================================
	// Next state.
	// ======================================================================
	// Both sources start the very same sequence; only the pin reset input, seen directly by the register bank, tells them apart.
	always_comb begin
		seq_d      = seq_q;
		seq_d.done = 1'b0;
		if (reset || soft_request) begin
			seq_d.state = URR_RESET;
			seq_d.count = 3'h0;
			seq_d.busy  = 1'b1;
		end else begin
			case (seq_q.state)
				URR_RESET: begin
					// The reset holds for four clocks, then releases.
					if (seq_q.count == RESET_COUNT_LAST) begin
						seq_d.state = URR_RUN;
						seq_d.busy  = 1'b0;
						seq_d.done  = 1'b1;
					end else begin
						seq_d.count = seq_q.count + 3'h1;
					end
				end
				URR_RUN: begin
					seq_d.busy = 1'b0;
				end
				default: begin
					seq_d.state = URR_RUN;
				end
			endcase
		end
	end

	// ======================================================================
	// State register.
	// ======================================================================
	always_ff @(posedge clk_sys) begin
		seq_q <= seq_d;
	end

	assign regs_reset = seq_q.busy;
	assign reset_done = seq_q.done;

endmodule

`default_nettype wire

// *** urr_regs.sv ***
`default_nettype none


// ==========================================================================
// UART register bank with reset state logic and APB slave.
// ==========================================================================
module urr_regs
	import urr_pkg::*;
(
	input  wire logic                   clk_sys,       // System clock, 100 MHz.
	input  wire logic                   reset,         // Pin reset, synchronous, active high.
	input  wire urr_pkg::urr_apb_req_t  apb_req,       // APB request.
	output var  urr_pkg::urr_apb_rsp_t  apb_rsp,       // APB answer.
	input  wire urr_pkg::urr_modem_in_t modem_pins,    // Modem input pins, asynchronous.
	output logic                        reset_busy     // High while a reset is in progress.
);

	// All state of the register bank.
	typedef struct packed {
		logic [7:0]    int_enable;
		logic [7:0]    int_status;
		logic [7:0]    fifo_control;
		logic [7:0]    line_control;
		logic [7:0]    modem_control;
		logic [7:0]    line_status;
		logic [3:0]    modem_delta;
		logic [7:0]    extra_feature;
		logic [7:0]    scratch;
		logic [7:0]    divisor_low;
		logic [7:0]    divisor_high;
		logic [7:0]    tx_level;
		logic [7:0]    rx_level;
		logic [7:0]    enhanced_feature;
		logic [7:0]    resume_one;
		logic [7:0]    resume_two;
		logic [7:0]    pause_one;
		logic [7:0]    pause_two;
		logic [7:0]    tx_trigger;
		logic [7:0]    rx_trigger;
		logic [7:0]    flow_high;
		logic [7:0]    flow_low;
		logic [7:0]    prescaler;
		logic [7:0]    sampling;
		logic [7:0]    adv_control;
		urr_modem_in_t pin_meta;
		urr_modem_in_t pin_sync;
		urr_modem_in_t pin_last;
		logic          soft_req;
		logic          busy;
		urr_apb_rsp_t  rsp;
	} urr_regs_t;

	urr_regs_t  r_q;         // Registered state.
	urr_regs_t  r_d;         // Next state.
	logic       regs_reset;  // Sequencer holds the registers in reset.
	logic       reset_done;  // Sequencer finished a reset.
	logic       access;      // APB access phase this cycle.
	logic       wr;          // Write in access phase.
	logic [7:0] wbyte;       // Written byte.
	logic [7:0] modem_view;  // Modem status as read.

	// ======================================================================
	// Reset sequencer.
	// ======================================================================
	urr_reset_seq u_seq (
		.clk_sys      (clk_sys),
		.reset        (reset),
		.soft_request (r_q.soft_req),
		.regs_reset   (regs_reset),
		.reset_done   (reset_done)
	);

	assign access   = apb_req.psel && apb_req.penable;
	assign wr       = access && apb_req.pwrite;
	assign wbyte    = apb_req.pwdata[7:0];
	// Upper nibble follows the synchronised pins live, so it shows pin levels in reset too.
	assign modem_view = {r_q.pin_sync, r_q.modem_delta};

	// Read multiplexer, a byte in the low lane.
	function automatic logic [31:0] read_mux(input urr_regs_t s, input logic [7:0] a, input logic [7:0] mview);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_INTERRUPT_ENABLE: v = s.int_enable;
			ADDR_INTERRUPT_STATUS: v = s.int_status;
			ADDR_FIFO_CONTROL:     v = s.fifo_control;
			ADDR_LINE_CONTROL:     v = s.line_control;
			ADDR_MODEM_CONTROL:    v = s.modem_control;
			ADDR_LINE_STATUS:      v = s.line_status;
			ADDR_MODEM_STATUS:     v = mview;
			ADDR_EXTRA_FEATURE:    v = s.extra_feature;
			ADDR_SCRATCH:          v = s.scratch;
			ADDR_DIVISOR_LOW:      v = s.divisor_low;
			ADDR_DIVISOR_HIGH:     v = s.divisor_high;
			ADDR_TX_LEVEL:         v = s.tx_level;
			ADDR_RX_LEVEL:         v = s.rx_level;
			ADDR_ENHANCED_FEATURE: v = s.enhanced_feature;
			ADDR_RESUME_ONE:       v = s.resume_one;
			ADDR_RESUME_TWO:       v = s.resume_two;
			ADDR_PAUSE_ONE:        v = s.pause_one;
			ADDR_PAUSE_TWO:        v = s.pause_two;
			ADDR_TX_TRIGGER:       v = s.tx_trigger;
			ADDR_RX_TRIGGER:       v = s.rx_trigger;
			ADDR_FLOW_HIGH:        v = s.flow_high;
			ADDR_FLOW_LOW:         v = s.flow_low;
			ADDR_PRESCALER:        v = s.prescaler;
			ADDR_SAMPLING:         v = s.sampling;
			ADDR_ADV_CONTROL:      v = s.adv_control;
			ADDR_RESET_STATUS:     v = {7'h00, s.busy};
			default:               v = UNMAPPED_READ[7:0];
		endcase
		return {24'h00_0000, v};
	endfunction

	// True when the address names a register in the map.
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= ADDR_RESET_STATUS);
	endfunction

	// ======================================================================
	// Next state.
	// ======================================================================
	always_comb begin
		r_d            = r_q;
		r_d.soft_req   = 1'b0;
		r_d.busy       = regs_reset || r_q.soft_req;
		// Modem pins: two flip-flops before anything looks at them.
		r_d.pin_meta   = modem_pins;
		r_d.pin_sync   = r_q.pin_meta;
		r_d.pin_last   = r_q.pin_sync;
		// A pin change latches its delta bit; a read of modem status clears it, but a change wins.
		// Only the cycle that takes the read clears, so a change in the second access cycle is kept.
		if (access && !r_q.rsp.pready && !apb_req.pwrite && apb_req.paddr == ADDR_MODEM_STATUS) begin
			r_d.modem_delta = 4'h0;
		end
		r_d.modem_delta = r_d.modem_delta | (r_q.pin_sync ^ r_q.pin_last);

		// The answer comes one cycle after the request is taken, so an access phase lasts two cycles.
		r_d.rsp.pready  = access && !r_q.rsp.pready;
		r_d.rsp.pslverr = access && !r_q.rsp.pready && !mapped(apb_req.paddr);
		r_d.rsp.prdata  = (access && !apb_req.pwrite) ? read_mux(r_q, apb_req.paddr, modem_view) : 32'h0000_0000;

		// Writes are taken in the access cycle; writes during a reset are dropped.
		if (wr && !r_q.rsp.pready && !regs_reset) begin
			case (apb_req.paddr)
				ADDR_INTERRUPT_ENABLE: r_d.int_enable       = wbyte;
				ADDR_FIFO_CONTROL:     r_d.fifo_control     = wbyte;
				ADDR_LINE_CONTROL:     r_d.line_control     = wbyte;
				ADDR_MODEM_CONTROL:    r_d.modem_control    = wbyte;
				ADDR_EXTRA_FEATURE:    r_d.extra_feature    = wbyte;
				ADDR_SCRATCH:          r_d.scratch          = wbyte;
				ADDR_DIVISOR_LOW:      r_d.divisor_low      = wbyte;
				ADDR_DIVISOR_HIGH:     r_d.divisor_high     = wbyte;
				ADDR_ENHANCED_FEATURE: r_d.enhanced_feature = wbyte;
				ADDR_RESUME_ONE:       r_d.resume_one       = wbyte;
				ADDR_RESUME_TWO:       r_d.resume_two       = wbyte;
				ADDR_PAUSE_ONE:        r_d.pause_one        = wbyte;
				ADDR_PAUSE_TWO:        r_d.pause_two        = wbyte;
				ADDR_TX_TRIGGER:       r_d.tx_trigger       = wbyte;
				ADDR_RX_TRIGGER:       r_d.rx_trigger       = wbyte;
				ADDR_FLOW_HIGH:        r_d.flow_high        = wbyte;
				ADDR_FLOW_LOW:         r_d.flow_low         = wbyte;
				ADDR_PRESCALER:        r_d.prescaler        = wbyte;
				ADDR_SAMPLING:         r_d.sampling         = wbyte;
				ADDR_ADV_CONTROL: begin
					r_d.adv_control = wbyte;
					// Setting the soft reset bit launches the sequencer.
					r_d.soft_req    = wbyte[SOFT_RESET_BIT];
					r_d.busy        = r_d.busy || wbyte[SOFT_RESET_BIT];
				end
				default: begin
					r_d.soft_req = 1'b0;
				end
			endcase
		end

		// Shared reset state for both sources; the pin reset alone also loads adv_control, divisor and flow characters below.
		if (regs_reset) begin
			r_d.int_enable       = RESET_ZERO;
			r_d.int_status       = RESET_INT_STATUS;
			r_d.fifo_control     = RESET_ZERO;
			r_d.line_control     = RESET_ZERO;
			r_d.modem_control    = RESET_ZERO;
			r_d.line_status      = RESET_LINE_STATUS;
			r_d.modem_delta      = 4'h0;
			r_d.extra_feature    = RESET_ZERO;
			r_d.scratch          = RESET_SCRATCH;
			r_d.tx_level         = RESET_ZERO;
			r_d.rx_level         = RESET_ZERO;
			r_d.enhanced_feature = RESET_ZERO;
			r_d.tx_trigger       = RESET_ZERO;
			r_d.rx_trigger       = RESET_ZERO;
			r_d.flow_high        = RESET_ZERO;
			r_d.flow_low         = RESET_ZERO;
			r_d.prescaler        = RESET_ZERO;
			r_d.sampling         = RESET_ZERO;
			// Divisor and flow characters keep their contents through a soft reset.
		end
		// The soft reset bit drops to zero by itself once the reset completes.
		if (reset_done) begin
			r_d.adv_control[SOFT_RESET_BIT] = 1'b0;
		end
		// The pin reset also clears the whole advanced control and gives the unspecified
		// registers a known value, so simulation never starts from unknowns.
		if (reset) begin
			r_d.adv_control  = RESET_ZERO;
			r_d.divisor_low  = DIVISOR_POWERUP;
			r_d.divisor_high = DIVISOR_POWERUP;
			r_d.resume_one   = FLOW_CHAR_POWERUP;
			r_d.resume_two   = FLOW_CHAR_POWERUP;
			r_d.pause_one    = FLOW_CHAR_POWERUP;
			r_d.pause_two    = FLOW_CHAR_POWERUP;
			r_d.modem_delta  = 4'h0;
			r_d.soft_req     = 1'b0;
			r_d.busy         = 1'b1;
			r_d.rsp          = '0;
		end
	end

	// ======================================================================
	// State register.
	// ======================================================================
	always_ff @(posedge clk_sys) begin
		r_q <= r_d;
	end

	assign apb_rsp    = r_q.rsp;
	assign reset_busy = r_q.busy;

endmodule

`default_nettype wire

// *** urr_regs_asserts.sv ***
`default_nettype none

// ==========================================================================
// Port checker for the register bank reset behaviour.
// ==========================================================================
module urr_regs_asserts
	import urr_pkg::*;
(
	input wire logic                   clk_sys,    // System clock.
	input wire logic                   reset,      // Pin reset.
	input wire urr_pkg::urr_apb_req_t  apb_req,    // Bus request.
	input wire urr_pkg::urr_apb_rsp_t  apb_rsp,    // Bus answer.
	input wire urr_pkg::urr_modem_in_t modem_pins, // Modem pins.
	input wire logic                   reset_busy  // Reset in progress.
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// A read answer arrives while the master still holds its address.
	wire logic rd_ok   = apb_req.psel && !apb_req.pwrite && apb_rsp.pready;
	// First access cycle, the edge at which the bank takes a request.
	wire logic taken   = apb_req.psel && apb_req.penable && !apb_rsp.pready;
	// A taken write that sets the soft reset bit.
	wire logic soft_wr = taken && apb_req.pwrite && apb_req.paddr == ADDR_ADV_CONTROL
		&& apb_req.pwdata[SOFT_RESET_BIT];

	// ======================================================================
	// Reset and answer timing.
	// ======================================================================
	AST_PIN_LEN: assert property ($fell(reset) |-> reset_busy [*4] ##[1:4] !reset_busy)
		else $error("busy span after pin reset is wrong");
	AST_SOFT_GO: assert property (soft_wr |-> ##[1:2] reset_busy)
		else $error("soft reset write did not start a reset");
	AST_SOFT_LEN: assert property ($rose(reset_busy) && !$past(reset) |-> reset_busy [*4] ##[1:4] !reset_busy)
		else $error("busy span after soft reset is wrong");
	AST_ANSWER: assert property (taken |=> apb_rsp.pready)
		else $error("no answer one cycle after a taken request");

	// ======================================================================
	// Read values of status registers and of the soft reset bit.
	// ======================================================================
	AST_INT_STATUS: assert property (rd_ok && apb_req.paddr == ADDR_INTERRUPT_STATUS
		|-> apb_rsp.prdata == {24'h0, RESET_INT_STATUS})
		else $error("interrupt status is not the idle value");
	AST_LINE_STATUS: assert property (rd_ok && apb_req.paddr == ADDR_LINE_STATUS
		|-> apb_rsp.prdata == {24'h0, RESET_LINE_STATUS})
		else $error("line status is not the empty value");
	// The pins must have been steady long enough to pass the synchroniser.
	AST_MODEM_STATUS: assert property (rd_ok && apb_req.paddr == ADDR_MODEM_STATUS
		&& modem_pins == $past(modem_pins, 4) |-> apb_rsp.prdata[7:4] == modem_pins)
		else $error("modem status does not show the pins");
	AST_SOFT_CLEAR: assert property (rd_ok && apb_req.paddr == ADDR_ADV_CONTROL
		|-> !apb_rsp.prdata[SOFT_RESET_BIT])
		else $error("soft reset bit did not clear itself");
endmodule

bind urr_regs urr_regs_asserts u_chk (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .modem_pins(modem_pins), .reset_busy(reset_busy));

`default_nettype wire

// *** urr_host.sv ***
`default_nettype none

// ==========================================================================
// Host processor model: an APB master with one transfer task.
// ==========================================================================
module urr_host
	import urr_pkg::*;
(
	input  wire logic                  clk_sys,    // System clock.
	input  wire urr_pkg::urr_apb_rsp_t apb_rsp,    // Bus answer.
	input  wire logic                  reset_busy, // Reset in progress.
	output var urr_pkg::urr_apb_req_t  apb_req     // Bus request.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero.
	initial apb_req = '0;

	// One transfer; it starts one edge after the last one released the bus.
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge clk_sys);
		// Register contents are not trusted until a reset has finished.
		while (reset_busy !== 1'b0) @(posedge clk_sys);
		apb_req.psel    <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite  <= wr;
		apb_req.paddr   <= addr;
		apb_req.pwdata  <= wdata;
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
		rdata = apb_rsp.prdata;
		err   = apb_rsp.pslverr;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
		// Released lines show junk, so stale values cannot pass for good ones.
		apb_req.pwrite  <= ~wr;
		apb_req.paddr   <= ~addr;
		apb_req.pwdata  <= ~wdata;
	endtask
endmodule

`default_nettype wire

// *** test_urr_regs.sv ***
`default_nettype none

// ==========================================================================
// Testbench: reset values after pin reset, soft reset and reset in mid-run.
// ==========================================================================
module test_urr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import urr_pkg::*;

	logic          clk_sys    = 1'b0; // System clock.
	logic          reset      = 1'b1; // Pin reset.
	urr_modem_in_t modem_pins = '0;   // Modem pin levels.
	urr_apb_req_t  apb_req;           // Bus request from the host.
	urr_apb_rsp_t  apb_rsp;           // Bus answer.
	logic          reset_busy;        // Reset in progress.
	int            n_errors        = 0; // Mismatches.
	int            samples_checked = 0; // Comparisons.
	logic [31:0]   rd_q;              // Last read data.
	logic          rd_e;              // Last error flag.

	// Byte registers with their reset values; read-only rows ignore writes.
	localparam int              NREG     = 17;
	localparam logic [7:0]      TAB_ADDR [NREG] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20,
		8'h2c, 8'h30, 8'h34, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c};
	localparam logic [7:0]      TAB_RST  [NREG] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [NREG-1:0] TAB_RO   = 17'h00322;

	// 100 MHz clock.
	always #5 clk_sys = ~clk_sys;

	urr_regs dut (.clk_sys(clk_sys), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.modem_pins(modem_pins), .reset_busy(reset_busy));
	urr_host host (.clk_sys(clk_sys), .apb_rsp(apb_rsp), .reset_busy(reset_busy), .apb_req(apb_req));

	// ======================================================================
	// Comparison and bus helpers.
	// ======================================================================
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Reads one register; addresses past the last one or off a word boundary are unmapped.
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rd_q, rd_e);
		chk($sformatf("read data %h", a), rd_q, exp);
		chk($sformatf("error flag %h", a), {31'h0, rd_e}, {31'h0, (a > ADDR_RESET_STATUS) || (a[1:0] != 2'b00)});
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rd_q, rd_e);
	endtask

	// Writes a distinct value to every row, read-only rows included.
	task fill();
		for (int i = 0; i < NREG; i++) wr(TAB_ADDR[i], {24'h0, 8'h80 | 8'(i)});
	endtask

	// Expects the fill pattern where writable, else the reset value.
	task check_table(input logic written);
		for (int i = 0; i < NREG; i++)
			rd_chk(TAB_ADDR[i], {24'h0, (written && !TAB_RO[i]) ? (8'h80 | 8'(i)) : TAB_RST[i]});
	endtask

	task final_report();
		$display("Comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ======================================================================
	// Main sequence.
	// ======================================================================
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		check_table(1'b0);
		rd_chk(ADDR_MODEM_STATUS, 32'h0);
		rd_chk(ADDR_ADV_CONTROL, 32'h0);
		rd_chk(8'h68, UNMAPPED_READ);
		rd_chk(8'h21, UNMAPPED_READ);
		rd_chk(ADDR_RESET_STATUS, 32'h0);
		$display("test pin reset values done");
		// Dirty every writable register in the table and raise change flags before a soft reset.
		fill();
		check_table(1'b1);
		modem_pins <= 4'hf;
		repeat (4) @(posedge clk_sys);
		rd_chk(ADDR_MODEM_STATUS, 32'h0000_00ff);
		modem_pins <= 4'h5;
		repeat (4) @(posedge clk_sys);
		wr(ADDR_ADV_CONTROL, 32'h0000_0002);
		chk("reset busy", {31'h0, reset_busy}, 32'h1);
		check_table(1'b0);
		rd_chk(ADDR_MODEM_STATUS, 32'h0000_0050);
		rd_chk(ADDR_ADV_CONTROL, 32'h0);
		$display("test soft reset done");
		// Pin reset in mid-run must leave the same table values as the soft one.
		fill();
		modem_pins <= 4'ha;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b1;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		check_table(1'b0);
		rd_chk(ADDR_MODEM_STATUS, 32'h0000_00a0);
		$display("test mid-run pin reset done");
		final_report();
	end

	// The run needs well under a thousand cycles; this cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		$display("Error watchdog expired");
		final_report();
	end
endmodule

`default_nettype wire
